/* rtl/post_adc_gain_consts.vh */
`ifndef POST_ADC_GAIN_CONSTS_VH
`define POST_ADC_GAIN_CONSTS_VH
`define IDX_CH2_GAIN 8'h0B
`define IDX_CH3_GAIN 8'h0C
`define IDX_CH4_GAIN 8'h0D
`define IDX_CONTROL 8'h0E
`define IDX_STATUS 8'h0F
`define GAIN_CODE_RESET 8'hA0
`define CONTROL_RESET 8'h02
`define GAIN_CODE_UNITY 9'h0A0
`define GAIN_CODE_MUTE 8'hFF
`define MANT_FRAC_BITS 6'h0F
`define OCTAVE_MSB 8
`define OCTAVE_LSB 4
`define FRAC_MSB 3
`define COMBINE_MSB 7
`define COMBINE_LSB 6
`define SILENCE_BIT 4
`define CALIBRATE_BIT 0
`define COMBINE_NORMAL 2'h0
`define COMBINE_TWO 2'h1
`define COMBINE_ONE 2'h2
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2
`define IDX_MSB 9
`define IDX_LSB 2
`define BYTE_MSB 7
`endif

/* rtl/gain_stage.v */
`include "post_adc_gain_consts.vh"
`default_nettype none
module gain_stage #(
  parameter W = 24
) (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire in_valid,
  input wire [W-1:0] in_sample,
  input wire [7:0] code,
  input wire silence,
  output reg out_valid,
  output reg [W-1:0] out_sample
);
  // 10^(-0.375*f/20) in q1.15 for the sixteen steps of one 6 dB octave
  function [15:0] mantissa;
    input [3:0] f;
    begin
      case (f)
        4'h0: mantissa = 16'h8000;
        4'h1: mantissa = 16'h7A98;
        4'h2: mantissa = 16'h756A;
        4'h3: mantissa = 16'h7074;
        4'h4: mantissa = 16'h6BB3;
        4'h5: mantissa = 16'h6726;
        4'h6: mantissa = 16'h62CA;
        4'h7: mantissa = 16'h5E9D;
        4'h8: mantissa = 16'h5A9E;
        4'h9: mantissa = 16'h56CA;
        4'hA: mantissa = 16'h531F;
        4'hB: mantissa = 16'h4F9C;
        4'hC: mantissa = 16'h4C3F;
        4'hD: mantissa = 16'h4906;
        4'hE: mantissa = 16'h45F0;
        default: mantissa = 16'h42FC;
      endcase
    end
  endfunction

  // code distance from unity, split into octave shift and fine step
  wire [8:0] delta = {1'b0, code} - `GAIN_CODE_UNITY;
  wire [4:0] octave = delta[`OCTAVE_MSB:`OCTAVE_LSB];
  wire [5:0] shift_s = `MANT_FRAC_BITS + {octave[4], octave};
  wire [4:0] shift = shift_s[4:0];
  wire signed [16:0] mant_s = {1'b0, mantissa(delta[`FRAC_MSB:0])};
  wire signed [W+16:0] product = $signed(in_sample) * mant_s;
  wire signed [W+16:0] scaled = product >>> shift;
  wire fits = (&scaled[W+16:W-1]) | ~(|scaled[W+16:W-1]);
  wire [W-1:0] sat_max = {1'b0, {(W-1){1'b1}}};
  wire [W-1:0] sat_min = {1'b1, {(W-1){1'b0}}};
  wire [W-1:0] clipped = fits ? scaled[W-1:0] : (scaled[W+16] ? sat_min : sat_max);
  wire muted = silence | (code == `GAIN_CODE_MUTE);

  // one sample per valid, code sampled with the sample itself
  always @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_sample <= {W{1'b0}};
    end else if (ce) begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_sample <= muted ? {W{1'b0}} : clipped;
      end
    end
  end
endmodule // gain_stage
`default_nettype wire

/* rtl/offset_calibrator.v */
`default_nettype none
module offset_calibrator #(
  parameter W = 24,
  parameter LOG2N = 8
) (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire start,
  input wire in_valid,
  input wire [W-1:0] in_sample,
  output reg out_valid,
  output reg [W-1:0] out_sample,
  output wire busy
);
  localparam IDLE = 1'b0;
  localparam ACCUM = 1'b1;
  reg state_reg;
  reg [LOG2N-1:0] count_reg;
  reg [W+LOG2N-1:0] acc_reg;
  reg [W-1:0] offset_reg;
  wire [W+LOG2N-1:0] acc_sum = acc_reg + {{LOG2N{in_sample[W-1]}}, in_sample};
  wire [W:0] diff = {in_sample[W-1], in_sample} - {offset_reg[W-1], offset_reg};
  wire diff_ovf = diff[W] ^ diff[W-1];
  wire [W-1:0] sat_max = {1'b0, {(W-1){1'b1}}};
  wire [W-1:0] sat_min = {1'b1, {(W-1){1'b0}}};
  wire [W-1:0] diff_sat = diff_ovf ? (diff[W] ? sat_min : sat_max) : diff[W-1:0];
  wire [LOG2N-1:0] count_one = {{(LOG2N-1){1'b0}}, 1'b1};

  assign busy = state_reg;

  // offset removal on the pass path, averaging of 2^LOG2N samples on request
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= IDLE;
      count_reg <= {LOG2N{1'b0}};
      acc_reg <= {(W+LOG2N){1'b0}};
      offset_reg <= {W{1'b0}};
      out_valid <= 1'b0;
      out_sample <= {W{1'b0}};
    end else if (ce) begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_sample <= diff_sat;
      end
      case (state_reg)
        IDLE: begin
          if (start) begin
            state_reg <= ACCUM;
            count_reg <= {LOG2N{1'b0}};
            acc_reg <= {(W+LOG2N){1'b0}};
          end
        end
        ACCUM: begin
          if (start) begin
            count_reg <= {LOG2N{1'b0}};
            acc_reg <= {(W+LOG2N){1'b0}};
          end else if (in_valid) begin
            acc_reg <= acc_sum;
            count_reg <= count_reg + count_one;
            if (&count_reg) begin
              offset_reg <= acc_sum[W+LOG2N-1:LOG2N];
              state_reg <= IDLE;
            end
          end
        end
        default: begin
          state_reg <= IDLE;
        end
      endcase
    end
  end
endmodule // offset_calibrator
`default_nettype wire

/* rtl/post_adc_gain_mute_control.v */
`include "post_adc_gain_consts.vh"
`default_nettype none
// What this block does
// - channels 2 to 4 each own an 8-bit gain code; code 0 gives +60 dB
// - each code increment lowers gain by 0.375 dB
// - code 0xA0 passes samples at unity; 0x9F gives +0.375 dB
// - codes above unity attenuate down to -35.25 dB at 0xFE; 0xFF mutes
// - gain registers reset to 0xA0 and are readable and writable
// - bits 7:6 of control pick normal, two- or one-channel combining
// - control bit 4 silences every channel whatever its gain code
// - writing 1 to control bit 0 starts a dc offset calibration
// - control resets to 0x02; reserved bits 3:1 read 001 and are overwritten by every write
module post_adc_gain_mute_control #(
  parameter SAMPLE_W = 24,
  parameter CAL_LOG2 = 8
) (
  input wire CLK,
  input wire SRST,
  input wire CE,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg HREADYOUT,
  output reg HRESP,
  output reg [31:0] HRDATA,
  input wire SAMPLE_VALID,
  input wire [SAMPLE_W-1:0] CH2_SAMPLE_IN,
  input wire [SAMPLE_W-1:0] CH3_SAMPLE_IN,
  input wire [SAMPLE_W-1:0] CH4_SAMPLE_IN,
  output wire OUT_VALID,
  output wire [SAMPLE_W-1:0] CH2_SAMPLE_OUT,
  output wire [SAMPLE_W-1:0] CH3_SAMPLE_OUT,
  output wire [SAMPLE_W-1:0] CH4_SAMPLE_OUT,
  output wire [1:0] CHANNEL_COMBINE_SELECT,
  output wire GLOBAL_SILENCE,
  output wire [2:0] CAL_BUSY
);
  localparam NCH = 3;
  localparam W = SAMPLE_W;

  // register file
  reg [7:0] ch2_gain_code_reg;
  reg [7:0] ch3_gain_code_reg;
  reg [7:0] ch4_gain_code_reg;
  reg [7:0] control_reg;
  reg [7:0] ch2_gain_code_next;
  reg [7:0] ch3_gain_code_next;
  reg [7:0] ch4_gain_code_next;
  reg [7:0] control_next;

  // bus bookkeeping
  reg wr_pend_reg;
  reg [7:0] wr_idx_reg;
  reg offset_calibrate_trigger_reg;
  reg [31:0] rd_word;

  // datapath wiring, three lanes packed low lane first
  wire [NCH*W-1:0] raw_bus;
  wire [NCH*W-1:0] cal_bus;
  wire [NCH*W-1:0] comb_bus;
  wire [NCH*W-1:0] out_bus;
  wire [NCH*8-1:0] code_bus;
  wire [NCH-1:0] cal_valid;
  wire [NCH-1:0] gain_valid;
  wire [NCH-1:0] busy_bus;

  // address phase qualification
  wire addr_take = HSEL & HTRANS[`HTRANS_NONSEQ_BIT] & HREADY;
  wire [7:0] take_idx = HADDR[`IDX_MSB:`IDX_LSB];
  wire high_zero = ~(|HADDR[31:`IDX_MSB+1]);
  wire aligned = ~(|HADDR[`IDX_LSB-1:0]);
  wire size_ok = (HSIZE <= `HSIZE_WORD);
  wire take_ok = high_zero & aligned & size_ok;
  wire [7:0] wr_byte = HWDATA[`BYTE_MSB:0];

  // combine field as seen by the datapath; reserved value runs as normal
  wire [1:0] combine_raw = control_reg[`COMBINE_MSB:`COMBINE_LSB];
  wire combine_two = (combine_raw == `COMBINE_TWO);
  wire combine_one = (combine_raw == `COMBINE_ONE);
  wire silence = control_reg[`SILENCE_BIT];

  assign CHANNEL_COMBINE_SELECT = combine_raw;
  assign GLOBAL_SILENCE = silence;
  assign CAL_BUSY = busy_bus;
  assign OUT_VALID = gain_valid[0];
  assign CH2_SAMPLE_OUT = out_bus[W-1:0];
  assign CH3_SAMPLE_OUT = out_bus[2*W-1:W];
  assign CH4_SAMPLE_OUT = out_bus[3*W-1:2*W];
  assign raw_bus = {CH4_SAMPLE_IN, CH3_SAMPLE_IN, CH2_SAMPLE_IN};
  assign code_bus = {ch4_gain_code_reg, ch3_gain_code_reg, ch2_gain_code_reg};

  // next register values, including the write in its data phase
  always @* begin
    ch2_gain_code_next = ch2_gain_code_reg;
    ch3_gain_code_next = ch3_gain_code_reg;
    ch4_gain_code_next = ch4_gain_code_reg;
    control_next = control_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        `IDX_CH2_GAIN: begin
          ch2_gain_code_next = wr_byte;
        end
        `IDX_CH3_GAIN: begin
          ch3_gain_code_next = wr_byte;
        end
        `IDX_CH4_GAIN: begin
          ch4_gain_code_next = wr_byte;
        end
        `IDX_CONTROL: begin
          control_next = wr_byte;
        end
        default: begin
          control_next = control_reg;
        end
      endcase
    end
  end

  // read mux over next values so a read right after a write sees it
  always @* begin
    rd_word = 32'h0000_0000;
    case (take_idx)
      `IDX_CH2_GAIN: begin
        rd_word = {24'h00_0000, ch2_gain_code_next};
      end
      `IDX_CH3_GAIN: begin
        rd_word = {24'h00_0000, ch3_gain_code_next};
      end
      `IDX_CH4_GAIN: begin
        rd_word = {24'h00_0000, ch4_gain_code_next};
      end
      `IDX_CONTROL: begin
        rd_word = {24'h00_0000, control_next};
      end
      `IDX_STATUS: begin
        rd_word = {29'h0000_0000, busy_bus};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (~take_ok) begin
      rd_word = 32'h0000_0000;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  always @(posedge CLK) begin
    if (SRST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else if (CE) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_reg <= addr_take & HWRITE & take_ok;
      if (addr_take) begin
        wr_idx_reg <= take_idx;
      end
      if (addr_take & ~HWRITE) begin
        HRDATA <= rd_word;
      end else begin
        HRDATA <= 32'h0000_0000;
      end
    end
  end

  // register update and calibration request
  always @(posedge CLK) begin
    if (SRST) begin
      ch2_gain_code_reg <= `GAIN_CODE_RESET;
      ch3_gain_code_reg <= `GAIN_CODE_RESET;
      ch4_gain_code_reg <= `GAIN_CODE_RESET;
      control_reg <= `CONTROL_RESET;
      offset_calibrate_trigger_reg <= 1'b0;
    end else if (CE) begin
      ch2_gain_code_reg <= ch2_gain_code_next;
      ch3_gain_code_reg <= ch3_gain_code_next;
      ch4_gain_code_reg <= ch4_gain_code_next;
      control_reg <= control_next;
      // every write of a 1 starts a fresh run
      offset_calibrate_trigger_reg <= wr_pend_reg & (wr_idx_reg == `IDX_CONTROL) &
        wr_byte[`CALIBRATE_BIT];
    end
  end

  // pair 3/4 average used by both combining modes
  wire [W:0] pair_sum = {cal_bus[2*W-1], cal_bus[2*W-1:W]} +
    {cal_bus[3*W-1], cal_bus[3*W-1:2*W]};
  wire [W-1:0] pair_avg = pair_sum[W:1];

  // lanes 3/4 combine here; one-channel mode also puts the pair average on lane 2
  assign comb_bus[W-1:0] = combine_one ? pair_avg : cal_bus[W-1:0];
  assign comb_bus[2*W-1:W] = (combine_two | combine_one) ? pair_avg :
    cal_bus[2*W-1:W];
  assign comb_bus[3*W-1:2*W] = (combine_two | combine_one) ? pair_avg :
    cal_bus[3*W-1:2*W];

  // per-lane offset removal and gain
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : lane
      offset_calibrator #(
        .W(W),
        .LOG2N(CAL_LOG2)
      ) u_cal (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .start(offset_calibrate_trigger_reg),
        .in_valid(SAMPLE_VALID),
        .in_sample(raw_bus[(i+1)*W-1:i*W]),
        .out_valid(cal_valid[i]),
        .out_sample(cal_bus[(i+1)*W-1:i*W]),
        .busy(busy_bus[i])
      );
      gain_stage #(
        .W(W)
      ) u_gain (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .in_valid(cal_valid[i]),
        .in_sample(comb_bus[(i+1)*W-1:i*W]),
        .code(code_bus[(i+1)*8-1:i*8]),
        .silence(silence),
        .out_valid(gain_valid[i]),
        .out_sample(out_bus[(i+1)*W-1:i*W])
      );
    end
  endgenerate
endmodule // post_adc_gain_mute_control
`default_nettype wire

/* tb/gain_mon_monitor.sv */
`default_nettype none
module gain_mon #(
  parameter SAMPLE_W = 24
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic SAMPLE_VALID,
  input wire logic OUT_VALID,
  input wire logic [SAMPLE_W-1:0] CH2_SAMPLE_OUT,
  input wire logic [SAMPLE_W-1:0] CH3_SAMPLE_OUT,
  input wire logic [SAMPLE_W-1:0] CH4_SAMPLE_OUT,
  input wire logic [1:0] CHANNEL_COMBINE_SELECT,
  input wire logic GLOBAL_SILENCE,
  input wire logic [2:0] CAL_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_reg;
  wire [3*SAMPLE_W-1:0] outs = {CH2_SAMPLE_OUT, CH3_SAMPLE_OUT, CH4_SAMPLE_OUT};
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // marks the data phase of an accepted read
  always @(posedge CLK) rd_reg <= !SRST && HSEL && HTRANS[1] && HREADY && CE && !HWRITE;
  // control write, ending at its data phase
  sequence ctl_wr;
    HSEL && HTRANS[1] && HREADY && CE && HWRITE && HADDR == 32'h0000_0038 ##1 1'b1;
  endsequence
  sequence cal_wr;
    ctl_wr ##0 HWDATA[0];
  endsequence
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!rd_reg |-> HRDATA == 32'h0000_0000)
    else $error("read data outside data phase");
  a_out_delay: assert property (SAMPLE_VALID && CE |-> ##2 OUT_VALID)
    else $error("output valid late");
  a_no_stray: assert property (OUT_VALID |-> $past(SAMPLE_VALID, 2))
    else $error("output valid without input");
  a_out_hold: assert property (!OUT_VALID |-> $stable(outs))
    else $error("outputs moved without valid");
  a_silence_zero: assert property (GLOBAL_SILENCE && $past(GLOBAL_SILENCE) && OUT_VALID |-> outs == 0)
    else $error("silenced output not zero");
  a_ctl_fields: assert property (ctl_wr |=> CHANNEL_COMBINE_SELECT == $past(HWDATA[7:6]) && GLOBAL_SILENCE == $past(HWDATA[4]))
    else $error("control fields not mirrored");
  a_cal_start: assert property (cal_wr |-> ##[2:3] CAL_BUSY == 3'h7)
    else $error("calibration did not start");
endmodule // gain_mon
bind post_adc_gain_mute_control gain_mon #(.SAMPLE_W(SAMPLE_W)) mon (
  .CLK(CLK), .SRST(SRST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .HRDATA(HRDATA), .SAMPLE_VALID(SAMPLE_VALID), .OUT_VALID(OUT_VALID),
  .CH2_SAMPLE_OUT(CH2_SAMPLE_OUT), .CH3_SAMPLE_OUT(CH3_SAMPLE_OUT),
  .CH4_SAMPLE_OUT(CH4_SAMPLE_OUT), .CHANNEL_COMBINE_SELECT(CHANNEL_COMBINE_SELECT),
  .GLOBAL_SILENCE(GLOBAL_SILENCE), .CAL_BUSY(CAL_BUSY));
`default_nettype wire

/* tb/gain_host.sv */
`default_nettype none
module gain_host (
  input wire logic CLK,
  input wire logic HREADY,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    HSIZE = 3'h2;
  end
  // single word transfer, each phase held until ready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge CLK); while (!HREADY);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= w ? d : ~HWDATA;
    do @(posedge CLK); while (!HREADY);
  endtask
endmodule // gain_host
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, SRST, CE, HSEL, HWRITE, HREADYOUT, HRESP, SAMPLE_VALID, OUT_VALID, GLOBAL_SILENCE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS, CHANNEL_COMBINE_SELECT, md;
  logic [2:0] HSIZE, CAL_BUSY;
  logic [23:0] I2, I3, I4, O2, O3, O4;
  logic [72:0] ex;
  logic [72:0] sq[$];
  logic [31:0] rq[$];
  logic [7:0] gn[2:4];
  logic rd_ph, sil;
  int off[2:4];
  int mismatches, tests_run;
  localparam logic [7:0] CD[8] = '{8'h00, 8'h01, 8'h90, 8'hA0, 8'hA1, 8'hB0, 8'hFE, 8'hFF};
  // fine step factors of one 6 dB octave, q1.15
  localparam logic [15:0] MT[16] = '{16'h8000, 16'h7A98, 16'h756A, 16'h7074, 16'h6BB3,
    16'h6726, 16'h62CA, 16'h5E9D, 16'h5A9E, 16'h56CA, 16'h531F, 16'h4F9C, 16'h4C3F,
    16'h4906, 16'h45F0, 16'h42FC};
  gain_host host (.CLK(CLK), .HREADY(HREADYOUT), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));
  post_adc_gain_mute_control #(.SAMPLE_W(24), .CAL_LOG2(2)) uut (.CLK(CLK), .SRST(SRST),
    .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .SAMPLE_VALID(SAMPLE_VALID), .CH2_SAMPLE_IN(I2), .CH3_SAMPLE_IN(I3),
    .CH4_SAMPLE_IN(I4), .OUT_VALID(OUT_VALID), .CH2_SAMPLE_OUT(O2), .CH3_SAMPLE_OUT(O3),
    .CH4_SAMPLE_OUT(O4), .CHANNEL_COMBINE_SELECT(CHANNEL_COMBINE_SELECT),
    .GLOBAL_SILENCE(GLOBAL_SILENCE), .CAL_BUSY(CAL_BUSY));
  // expected gain: 6 dB per 16 codes, mantissa per step
  function automatic logic [23:0] gx(input int x, input logic [7:0] c);
    longint p;
    int d;
    logic [15:0] m;
    d = int'(c) - int'(8'hA0);
    m = MT[d[3:0]];
    p = (longint'(x) * longint'(m)) >>> (15 + (d >>> 4));
    if (c == 8'hFF || sil) p = 0;
    if (p[63:23] != {41{p[63]}}) p[23:0] = {p[63], {23{!p[63]}}};
    return p[23:0];
  endfunction
  task automatic cmp(input string n, input logic [72:0] e, input logic [72:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic setg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    host.xfer(1'b1, 32'h0000_002C, {24'hFF_FFFF, a});
    host.xfer(1'b1, 32'h0000_0030, {24'h00_0000, b});
    host.xfer(1'b1, 32'h0000_0034, {24'h00_0000, c});
    gn = '{a, b, c};
  endtask
  task automatic setc(input logic [7:0] v);
    host.xfer(1'b1, 32'h0000_0038, {24'h00_0000, v});
    {md, sil} = {v[7:6], v[4]};
    @(posedge CLK);
  endtask
  // note the expected frame, then present it
  task automatic smp(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c,
      input logic care);
    int o2, o3, o4, av;
    o2 = $signed(a) - off[2];
    o3 = $signed(b) - off[3];
    o4 = $signed(c) - off[4];
    av = (o3 + o4) >>> 1;
    if (md == 2'h1 || md == 2'h2) {o3, o4} = {av, av};
    if (md == 2'h2) o2 = av;
    sq.push_back({care, gx(o2, gn[2]), gx(o3, gn[3]), gx(o4, gn[4])});
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    {I2, I3, I4} <= {a, b, c};
  endtask
  task automatic rnd(input int n);
    repeat (n) smp(24'($urandom), 24'($urandom), 24'($urandom), 1'b1);
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  // result watcher: read data and output frames against oldest notes
  always @(posedge CLK) begin
    if (rd_ph && HREADYOUT) cmp("read data", rq.pop_front(), HRDATA);
    rd_ph <= HSEL && HTRANS[1] && !HWRITE && HREADYOUT && !SRST;
    if (OUT_VALID) begin
      ex = sq.pop_front();
      if (ex[72]) cmp("samples", ex, {1'b1, O2, O3, O4});
    end
  end
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    #(40 * 10000);
    mismatches++;
    print_verdict;
  end
  initial begin
    void'($urandom(2487));
    {SRST, CE, SAMPLE_VALID, I2, I3, I4, rd_ph, md, sil} = {2'b11, 77'h0};
    gn = '{8'hA0, 8'hA0, 8'hA0};
    off = '{0, 0, 0};
    repeat (12) @(posedge CLK);
    SRST <= 1'b0;
    rd(32'h0000_002C, 32'h0000_00A0);
    rd(32'h0000_0034, 32'h0000_00A0);
    rd(32'h0000_0038, 32'h0000_0002);
    setg(8'hA0, 8'h5A, 8'hA0);
    rd(32'h0000_002C, 32'h0000_00A0);
    rd(32'h0000_0030, 32'h0000_005A);
    host.xfer(1'b1, 32'h0000_0040, 32'h0000_00FF);
    rd(32'h0000_0040, 32'h0000_0000);
    setg(8'hA0, 8'hA0, 8'hA0);
    for (int m = 0; m < 4; m++) begin
      setc({m[1:0], 6'h02});
      cmp("select", md, CHANNEL_COMBINE_SELECT);
      rnd(3);
    end
    setc(8'h12);
    cmp("silence", 1'b1, GLOBAL_SILENCE);
    rnd(3);
    setc(8'h03);
    rd(32'h0000_003C, 32'h0000_0007);
    repeat (8) smp(24'h00_0064, 24'hFF_FFCE, 24'h00_0007, 1'b0);
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    for (int i = 0; i < 300 && CAL_BUSY !== 3'h0; i++) @(posedge CLK);
    cmp("cal busy", 3'h0, CAL_BUSY);
    rd(32'h0000_003C, 32'h0000_0000);
    off = '{$signed(24'h00_0064), $signed(24'hFF_FFCE), $signed(24'h00_0007)};
    setc(8'h02);
    rnd(4);
    for (int i = 0; i < 8; i++) begin
      setg(CD[i], CD[(i + 3) % 8], CD[(i + 5) % 8]);
      rnd(3);
    end
    print_verdict;
  end
endmodule // tb
`default_nettype wire
